/* crf_pkg.sv */
/*
 * Shared constants and carrier types for the CPU register file.
 * Assumes an APB master on the register port and CPU execution logic on the event ports.
 */
package crf_pkg;

    // ------------------------------------------------------------
    // Register byte offsets on the APB port
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_DATA0 = 8'h00;
    localparam logic [7:0] OFF_DATA1 = 8'h04;
    localparam logic [7:0] OFF_DATA2 = 8'h08;
    localparam logic [7:0] OFF_DATA3 = 8'h0c;
    localparam logic [7:0] OFF_ADDR0 = 8'h10;
    localparam logic [7:0] OFF_ADDR1 = 8'h14;
    localparam logic [7:0] OFF_FRAME = 8'h18;
    localparam logic [7:0] OFF_PAIR_LO = 8'h1c;
    localparam logic [7:0] OFF_PAIR_HI = 8'h20;
    localparam logic [7:0] OFF_APAIR = 8'h24;
    localparam logic [7:0] OFF_D0_HI = 8'h28;
    localparam logic [7:0] OFF_D0_LO = 8'h2c;
    localparam logic [7:0] OFF_D1_HI = 8'h30;
    localparam logic [7:0] OFF_D1_LO = 8'h34;
    localparam logic [7:0] OFF_PC = 8'h38;
    localparam logic [7:0] OFF_VTB = 8'h3c;
    localparam logic [7:0] OFF_USP = 8'h40;
    localparam logic [7:0] OFF_ISP = 8'h44;
    localparam logic [7:0] OFF_SB = 8'h48;
    localparam logic [7:0] OFF_FLAGS = 8'h4c;
    localparam logic [7:0] OFF_SP_SEL = 8'h50;

    // ------------------------------------------------------------
    // Banked register counts and flag bit positions
    // ------------------------------------------------------------
    localparam int NUM_BANKED = 7;
    localparam int NUM_BANKS = 2;
    localparam int FLG_C = 0;
    localparam int FLG_D = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_S = 3;
    localparam int FLG_B = 4;
    localparam int FLG_O = 5;
    localparam int FLG_I = 6;
    localparam int FLG_U = 7;
    localparam int FLG_IPL_LO = 12;
    localparam int FLG_IPL_HI = 14;
    localparam logic [15:0] FLG_IMPL_MASK = 16'h70ff;
    localparam logic [5:0] SWINT_U_LAST = 6'h1f;

    // ------------------------------------------------------------
    // Reset values and vector constants
    // ------------------------------------------------------------
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [19:0] RST_ADDR = 20'h00000;
    localparam logic [15:0] RST_FLAGS = 16'h0000;
    localparam logic [19:0] FIXED_VEC_BASE = 20'hfffdc;
    localparam logic [5:0] FIXED_VEC_LAST = 6'h08;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic upd_c;
        logic upd_z;
        logic upd_s;
        logic upd_o;
        logic carry;
        logic overflow;
        logic [15:0] result;
    } crf_alu_s;

    typedef struct packed {
        logic ack;
        logic hw;
        logic swint;
        logic [5:0] swint_num;
    } crf_int_s;

    typedef struct packed {
        logic valid;
        logic maskable;
        logic [2:0] prio;
    } crf_irq_s;

    typedef struct packed {
        logic valid;
        logic fixed;
        logic [5:0] num;
    } crf_vec_s;

endpackage

/* crf_regfile.sv */
/*
 * CPU architectural register file: banked data, address and frame base registers,
 * program counter, vector table base, two stack pointers, static base and flags.
 * Assumes an APB master on pclk and CPU execution logic driving the event ports
 * synchronously to pclk.
 */
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
module crf_regfile #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Execution events
    input wire crf_pkg::crf_alu_s alu_upd,
    input wire crf_pkg::crf_int_s int_evt,
    input wire crf_pkg::crf_irq_s irq_req,
    input wire crf_pkg::crf_vec_s vec_req,
    input wire logic instr_done,
    // CPU views
    output logic [19:0] program_counter,
    output logic [15:0] processor_flags,
    output logic [15:0] stack_pointer,
    output logic irq_accept,
    output logic step_req,
    output logic [19:0] vector_fetch_addr
);
    import crf_pkg::*;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must lie between 8 and 32");
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [15:0] bank_r [NUM_BANKS][NUM_BANKED];
    logic [19:0] pc_r;
    logic [19:0] vtb_r;
    logic [15:0] usp_r;
    logic [15:0] isp_r;
    logic [15:0] sb_r;
    logic [15:0] flags_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic irq_accept_r;
    logic step_req_r;
    logic [19:0] vec_addr_r;
    logic [15:0] sp_view_r;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Write effect of one access on banked register k: {hit, new value}
    function automatic logic [16:0] bank_wr(input int k, input logic [7:0] off,
                                            input logic [31:0] wd, input logic [15:0] cur);
        logic [16:0] res;
        res = {1'b0, cur};
        case (k)
            0: begin
                if (off == OFF_DATA0 || off == OFF_PAIR_LO) res = {1'b1, wd[15:0]};
                if (off == OFF_D0_HI) res = {1'b1, wd[7:0], cur[7:0]};
                if (off == OFF_D0_LO) res = {1'b1, cur[15:8], wd[7:0]};
            end
            1: begin
                if (off == OFF_DATA1 || off == OFF_PAIR_HI) res = {1'b1, wd[15:0]};
                if (off == OFF_D1_HI) res = {1'b1, wd[7:0], cur[7:0]};
                if (off == OFF_D1_LO) res = {1'b1, cur[15:8], wd[7:0]};
            end
            2: begin
                if (off == OFF_DATA2) res = {1'b1, wd[15:0]};
                if (off == OFF_PAIR_LO) res = {1'b1, wd[31:16]};
            end
            3: begin
                if (off == OFF_DATA3) res = {1'b1, wd[15:0]};
                if (off == OFF_PAIR_HI) res = {1'b1, wd[31:16]};
            end
            4: begin
                if (off == OFF_ADDR0 || off == OFF_APAIR) res = {1'b1, wd[15:0]};
            end
            5: begin
                if (off == OFF_ADDR1) res = {1'b1, wd[15:0]};
                if (off == OFF_APAIR) res = {1'b1, wd[31:16]};
            end
            6: begin
                if (off == OFF_FRAME) res = {1'b1, wd[15:0]};
            end
            default: res = {1'b0, cur};
        endcase
        return res;
    endfunction

    // Offset recognised by the map
    function automatic logic off_mapped(input logic [7:0] off);
        return (off[1:0] == 2'b00) && (off <= OFF_SP_SEL);
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire [7:0] off = paddr[7:0];
    wire hi_zero = (ADDR_W > 8) ? (paddr >> 8) == '0 : 1'b1;
    wire mapped = off_mapped(off) && hi_zero;
    wire setup = psel && !penable;
    wire wr_acc = psel && penable && pwrite && pready_r && mapped;
    wire bsel = flags_r[FLG_B];
    wire usel = flags_r[FLG_U];
    wire [15:0] cur_sp = usel ? usp_r : isp_r;
    wire [2:0] processor_priority_level = flags_r[FLG_IPL_HI:FLG_IPL_LO];

    wire [15:0] d0 = bank_r[bsel][0];
    wire [15:0] d1 = bank_r[bsel][1];
    wire [15:0] d2 = bank_r[bsel][2];
    wire [15:0] d3 = bank_r[bsel][3];
    wire [15:0] a0 = bank_r[bsel][4];
    wire [15:0] a1 = bank_r[bsel][5];
    wire [15:0] fb = bank_r[bsel][6];

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    wire [31:0] rd_word =
        (off == OFF_DATA0) ? {16'h0000, d0} :
        (off == OFF_DATA1) ? {16'h0000, d1} :
        (off == OFF_DATA2) ? {16'h0000, d2} :
        (off == OFF_DATA3) ? {16'h0000, d3} :
        (off == OFF_ADDR0) ? {16'h0000, a0} :
        (off == OFF_ADDR1) ? {16'h0000, a1} :
        (off == OFF_FRAME) ? {16'h0000, fb} :
        (off == OFF_PAIR_LO) ? {d2, d0} :
        (off == OFF_PAIR_HI) ? {d3, d1} :
        (off == OFF_APAIR) ? {a1, a0} :
        (off == OFF_D0_HI) ? {24'h000000, d0[15:8]} :
        (off == OFF_D0_LO) ? {24'h000000, d0[7:0]} :
        (off == OFF_D1_HI) ? {24'h000000, d1[15:8]} :
        (off == OFF_D1_LO) ? {24'h000000, d1[7:0]} :
        (off == OFF_PC) ? {12'h000, pc_r} :
        (off == OFF_VTB) ? {12'h000, vtb_r} :
        (off == OFF_USP) ? {16'h0000, usp_r} :
        (off == OFF_ISP) ? {16'h0000, isp_r} :
        (off == OFF_SB) ? {16'h0000, sb_r} :
        (off == OFF_FLAGS) ? {16'h0000, flags_r & FLG_IMPL_MASK} :
        (off == OFF_SP_SEL) ? {16'h0000, cur_sp} :
        32'h00000000;

    // ------------------------------------------------------------
    // Banked write path
    // ------------------------------------------------------------
    logic [16:0] bank_wr_res [NUM_BANKED];
    for (genvar k = 0; k < NUM_BANKED; k++) begin : g_bank_wr
        assign bank_wr_res[k] = bank_wr(k, off, pwdata, bank_r[bsel][k]);
    end

    // ------------------------------------------------------------
    // Non-banked write path
    // ------------------------------------------------------------
    wire wr_pc = wr_acc && off == OFF_PC;
    wire wr_vtb = wr_acc && off == OFF_VTB;
    wire wr_usp = wr_acc && (off == OFF_USP || (off == OFF_SP_SEL && usel));
    wire wr_isp = wr_acc && (off == OFF_ISP || (off == OFF_SP_SEL && !usel));
    wire wr_sb = wr_acc && off == OFF_SB;
    wire wr_flg = wr_acc && off == OFF_FLAGS;

    // ------------------------------------------------------------
    // Flag update: software write first, hardware events override
    // ------------------------------------------------------------
    wire [15:0] flg_sw = wr_flg ? (pwdata[15:0] & FLG_IMPL_MASK) : flags_r;
    wire alu_c = alu_upd.valid && alu_upd.upd_c;
    wire alu_z = alu_upd.valid && alu_upd.upd_z;
    wire alu_s = alu_upd.valid && alu_upd.upd_s;
    wire alu_o = alu_upd.valid && alu_upd.upd_o;
    wire clr_u = (int_evt.ack && int_evt.hw) || (int_evt.swint && int_evt.swint_num <= SWINT_U_LAST);

    wire [15:0] flags_nxt = {
        1'b0,
        flg_sw[14:12],
        4'h0,
        clr_u ? 1'b0 : flg_sw[FLG_U],
        int_evt.ack ? 1'b0 : flg_sw[FLG_I],
        alu_o ? alu_upd.overflow : flg_sw[FLG_O],
        flg_sw[FLG_B],
        alu_s ? alu_upd.result[15] : flg_sw[FLG_S],
        alu_z ? (alu_upd.result == 16'h0000) : flg_sw[FLG_Z],
        int_evt.ack ? 1'b0 : flg_sw[FLG_D],
        alu_c ? alu_upd.carry : flg_sw[FLG_C]
    };

    // ------------------------------------------------------------
    // Interrupt, single-step and vector outputs
    // ------------------------------------------------------------
    wire irq_ok = irq_req.valid && (irq_req.prio > processor_priority_level) && (flags_r[FLG_I] || !irq_req.maskable);
    wire step_nxt = instr_done && flags_r[FLG_D];
    wire [5:0] fix_num = (vec_req.num > FIXED_VEC_LAST) ? FIXED_VEC_LAST : vec_req.num;
    wire [19:0] fix_addr = FIXED_VEC_BASE + {12'h000, fix_num, 2'b00};
    wire [19:0] rel_addr = vtb_r + {12'h000, vec_req.num, 2'b00};
    wire [19:0] vec_nxt = vec_req.fixed ? fix_addr : rel_addr;
    wire [15:0] usp_nxt = wr_usp ? pwdata[15:0] : usp_r;
    wire [15:0] isp_nxt = wr_isp ? pwdata[15:0] : isp_r;
    wire [15:0] sp_view_nxt = flags_nxt[FLG_U] ? usp_nxt : isp_nxt;

    // ------------------------------------------------------------
    // Banked registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                for (int k = 0; k < NUM_BANKED; k++) begin
                    bank_r[b][k] <= RST_WORD;
                end
            end
        end else begin
            for (int k = 0; k < NUM_BANKED; k++) begin
                if (wr_acc && bank_wr_res[k][16]) begin
                    bank_r[bsel][k] <= bank_wr_res[k][15:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_r <= RST_ADDR;
            vtb_r <= RST_ADDR;
            usp_r <= RST_WORD;
            isp_r <= RST_WORD;
            sb_r <= RST_WORD;
            flags_r <= RST_FLAGS;
        end else begin
            if (wr_pc) pc_r <= pwdata[19:0];
            if (wr_vtb) vtb_r <= pwdata[19:0];
            if (wr_sb) sb_r <= pwdata[15:0];
            usp_r <= usp_nxt;
            isp_r <= isp_nxt;
            flags_r <= flags_nxt;
        end
    end

    // ------------------------------------------------------------
    // APB answer: data captured in setup, ready in first access cycle
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r <= (setup && !pwrite && mapped) ? rd_word : 32'h00000000;
            pready_r <= setup;
            pslverr_r <= setup && !mapped;
        end
    end

    // ------------------------------------------------------------
    // CPU-side outputs
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_accept_r <= 1'b0;
            step_req_r <= 1'b0;
            vec_addr_r <= RST_ADDR;
            sp_view_r <= RST_WORD;
        end else begin
            irq_accept_r <= irq_ok;
            step_req_r <= step_nxt;
            if (vec_req.valid) vec_addr_r <= vec_nxt;
            sp_view_r <= sp_view_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign program_counter = pc_r;
    assign processor_flags = flags_r;
    assign stack_pointer = sp_view_r;
    assign irq_accept = irq_accept_r;
    assign step_req = step_req_r;
    assign vector_fetch_addr = vec_addr_r;

endmodule

/* crf_regfile_asserts.sv */
/*
 * Concurrent checks on the CPU register file ports.
 * Assumes binding to crf_regfile, single pclk domain, presetn async active low.
 */
module crf_regfile_asserts
    import crf_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Events
    input wire crf_pkg::crf_alu_s alu_upd,
    input wire crf_pkg::crf_int_s int_evt,
    input wire crf_pkg::crf_irq_s irq_req,
    input wire crf_pkg::crf_vec_s vec_req,
    input wire logic instr_done,
    // CPU views
    input wire logic [19:0] program_counter,
    input wire logic [15:0] processor_flags,
    input wire logic [15:0] stack_pointer,
    input wire logic irq_accept,
    input wire logic step_req,
    input wire logic [19:0] vector_fetch_addr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s; psel && !penable; endsequence
    sequence access_s; psel && penable; endsequence
    ready_in_access_a: assert property (setup_s ##1 access_s |-> pready)
        else $error("pready missing in first access cycle");
    ready_only_access_a: assert property (pready |-> access_s)
        else $error("pready outside access cycle");
    flag_reserved_a: assert property ((processor_flags & ~FLG_IMPL_MASK) == 16'h0000)
        else $error("reserved flag bit set");
    zero_flag_a: assert property (alu_upd.valid && alu_upd.upd_z |=>
        processor_flags[FLG_Z] == ($past(alu_upd.result) == 16'h0000)) else $error("zero flag wrong");
    sign_flag_a: assert property (alu_upd.valid && alu_upd.upd_s |=>
        processor_flags[FLG_S] == $past(alu_upd.result[15])) else $error("sign flag wrong");
    carry_flag_a: assert property (alu_upd.valid && alu_upd.upd_c |=>
        processor_flags[FLG_C] == $past(alu_upd.carry)) else $error("carry flag wrong");
    ovf_flag_a: assert property (alu_upd.valid && alu_upd.upd_o |=>
        processor_flags[FLG_O] == $past(alu_upd.overflow)) else $error("overflow flag wrong");
    ack_clears_a: assert property (int_evt.ack |=> !processor_flags[FLG_D] && !processor_flags[FLG_I])
        else $error("ack left debug or enable flag set");
    stack_sel_clear_a: assert property ((int_evt.ack && int_evt.hw) ||
        (int_evt.swint && int_evt.swint_num <= SWINT_U_LAST) |=> !processor_flags[FLG_U])
        else $error("stack select not cleared");
    irq_gate_a: assert property (1'b1 |=> irq_accept == $past(irq_req.valid &&
        (irq_req.prio > processor_flags[FLG_IPL_HI:FLG_IPL_LO]) && (processor_flags[FLG_I] || !irq_req.maskable)))
        else $error("interrupt acceptance wrong");
    step_pulse_a: assert property (1'b1 |=> step_req == $past(instr_done && processor_flags[FLG_D]))
        else $error("single step request wrong");
    fixed_vec_a: assert property (vec_req.valid && vec_req.fixed && vec_req.num <= FIXED_VEC_LAST |=>
        vector_fetch_addr == FIXED_VEC_BASE + {12'h000, $past(vec_req.num), 2'b00}) else $error("fixed vector wrong");
endmodule

bind crf_regfile crf_regfile_asserts #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .alu_upd(alu_upd), .int_evt(int_evt), .irq_req(irq_req), .vec_req(vec_req),
    .instr_done(instr_done), .program_counter(program_counter), .processor_flags(processor_flags),
    .stack_pointer(stack_pointer), .irq_accept(irq_accept), .step_req(step_req),
    .vector_fetch_addr(vector_fetch_addr));

/* cpu_register_file_flags_bench.sv */
/*
 * Self-checking bench for the CPU register file against a behavioural model.
 * Assumes crf_pkg and crf_regfile compiled first; drives all ports itself.
 */
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module cpu_register_file_flags_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import crf_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, instr_done = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r = 32'h2b, q;
    logic pready, pslverr, irq_accept, step_req, e;
    crf_alu_s alu_upd = '0;
    crf_int_s int_evt = '0;
    crf_irq_s irq_req = '0;
    crf_vec_s vec_req = '0;
    logic [19:0] program_counter, vector_fetch_addr, pc = 0, vtb = 0, va = 0;
    logic [15:0] processor_flags, stack_pointer, user_stack_pointer = 0, interrupt_stack_pointer = 0, sb = 0, fl = 0;
    logic [15:0] bk [2][8];
    logic xi, xs;
    int num_errors = 0, check_count = 0;
    crf_regfile uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .alu_upd(alu_upd), .int_evt(int_evt), .irq_req(irq_req), .vec_req(vec_req), .instr_done(instr_done),
        .program_counter(program_counter), .processor_flags(processor_flags), .stack_pointer(stack_pointer),
        .irq_accept(irq_accept), .step_req(step_req), .vector_fetch_addr(vector_fetch_addr));
    always #20 pclk = ~pclk;
    function automatic logic [31:0] nx(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] mr(logic [7:0] a);
        logic b;
        b = fl[FLG_B];
        case (a)
            OFF_DATA0, OFF_DATA1, OFF_DATA2, OFF_DATA3, OFF_ADDR0, OFF_ADDR1, OFF_FRAME: return {16'h0, bk[b][a[4:2]]};
            OFF_PAIR_LO: return {bk[b][2], bk[b][0]};
            OFF_PAIR_HI: return {bk[b][3], bk[b][1]};
            OFF_APAIR: return {bk[b][5], bk[b][4]};
            OFF_D0_HI: return {24'h0, bk[b][0][15:8]};
            OFF_D0_LO: return {24'h0, bk[b][0][7:0]};
            OFF_D1_HI: return {24'h0, bk[b][1][15:8]};
            OFF_D1_LO: return {24'h0, bk[b][1][7:0]};
            OFF_PC: return {12'h0, pc};
            OFF_VTB: return {12'h0, vtb};
            OFF_USP: return {16'h0, user_stack_pointer};
            OFF_ISP: return {16'h0, interrupt_stack_pointer};
            OFF_SB: return {16'h0, sb};
            OFF_FLAGS: return {16'h0, fl};
            OFF_SP_SEL: return {16'h0, fl[FLG_U] ? user_stack_pointer : interrupt_stack_pointer};
            default: return 32'h0;
        endcase
    endfunction
    task end_sim;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
        if (n >= 20) begin
            num_errors++;
            end_sim();
        end
        `CHK("slave error", a > OFF_SP_SEL || a[1:0] != 2'h0, e)
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic b;
        b = fl[FLG_B];
        apb(1'b1, a, d);
        case (a)
            OFF_DATA0, OFF_DATA1, OFF_DATA2, OFF_DATA3, OFF_ADDR0, OFF_ADDR1, OFF_FRAME: bk[b][a[4:2]] = d[15:0];
            OFF_PAIR_LO: {bk[b][2], bk[b][0]} = d;
            OFF_PAIR_HI: {bk[b][3], bk[b][1]} = d;
            OFF_APAIR: {bk[b][5], bk[b][4]} = d;
            OFF_D0_HI: bk[b][0][15:8] = d[7:0];
            OFF_D0_LO: bk[b][0][7:0] = d[7:0];
            OFF_D1_HI: bk[b][1][15:8] = d[7:0];
            OFF_D1_LO: bk[b][1][7:0] = d[7:0];
            OFF_PC: pc = d[19:0];
            OFF_VTB: vtb = d[19:0];
            OFF_USP: user_stack_pointer = d[15:0];
            OFF_ISP: interrupt_stack_pointer = d[15:0];
            OFF_SB: sb = d[15:0];
            OFF_FLAGS: fl = d[15:0] & FLG_IMPL_MASK;
            OFF_SP_SEL: if (fl[FLG_U]) user_stack_pointer = d[15:0]; else interrupt_stack_pointer = d[15:0];
            default: ;
        endcase
    endtask
    task sweep;
        for (int a = 0; a <= 'h5a; a += 2) begin
            apb(1'b0, a[7:0], 32'h0);
            `CHK("read data", a[1:0] == 0 ? mr(a[7:0]) : 32'h0, q)
        end
        `CHK("stack pointer", fl[FLG_U] ? user_stack_pointer : interrupt_stack_pointer, stack_pointer)
        `CHK("program counter", pc, program_counter)
    endtask
    initial begin
        foreach (bk[i, j]) bk[i][j] = 16'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1;
        sweep();
        for (int p = 0; p < 4; p++) begin
            for (int a = 0; a <= OFF_SP_SEL; a += 4) begin
                r = nx(r);
                wr(a[7:0], r);
            end
            sweep();
        end
        for (int k = 0; k < 8; k++) begin
            r = nx(r);
            wr(OFF_FLAGS, r);
            for (int c = 0; c < 40; c++) begin
                @(posedge pclk);
                xi = irq_req.valid && irq_req.prio > fl[14:12] && (fl[FLG_I] || !irq_req.maskable);
                xs = instr_done && fl[FLG_D];
                if (vec_req.valid)
                    va = vec_req.fixed ? FIXED_VEC_BASE + 20'(4 * (vec_req.num > 8 ? 8 : vec_req.num))
                                       : vtb + 20'(4 * vec_req.num);
                if (alu_upd.valid && alu_upd.upd_c) fl[FLG_C] = alu_upd.carry;
                if (alu_upd.valid && alu_upd.upd_z) fl[FLG_Z] = alu_upd.result == 16'h0;
                if (alu_upd.valid && alu_upd.upd_s) fl[FLG_S] = alu_upd.result[15];
                if (alu_upd.valid && alu_upd.upd_o) fl[FLG_O] = alu_upd.overflow;
                if (int_evt.ack) fl[FLG_D] = 0;
                if (int_evt.ack) fl[FLG_I] = 0;
                if ((int_evt.ack && int_evt.hw) || (int_evt.swint && int_evt.swint_num <= 6'd31)) fl[FLG_U] = 0;
                r = nx(r);
                q = r;
                r = nx(r);
                if (c < 39) begin
                    alu_upd <= crf_alu_s'(q[22:0] & {7'h7f, {16{q[27]}}});
                    int_evt <= {r[2:0] == 3'h0, r[3], r[6:4] == 3'h0, r[12:7]};
                    irq_req <= r[17:13];
                    vec_req <= {r[18], r[19], r[25:20]};
                    instr_done <= r[26];
                end else begin
                    alu_upd <= '0; int_evt <= '0; irq_req <= '0; vec_req <= '0; instr_done <= 0;
                end
                #1;
                `CHK("flags", fl, processor_flags)
                `CHK("irq accept", xi, irq_accept)
                `CHK("step request", xs, step_req)
                `CHK("vector address", va, vector_fetch_addr)
                `CHK("stack select", fl[FLG_U] ? user_stack_pointer : interrupt_stack_pointer, stack_pointer)
            end
        end
        end_sim();
    end
endmodule
